/* File: sim/adcsc_chain_assertions.sv */
`timescale 1ns/1ps
// ====
// port checks
module adcsc_chain_assertions
   import adcsc_pkg::*;
#(
   parameter int RESET_CYC = 18
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire adcsc_pkg::adcsc_pins_t pins,
   input wire logic conv_done,
   input wire logic dout,
   input wire logic dout_oe,
   input wire logic result_ready_n,
   input wire logic converting,
   input wire logic standby,
   input wire logic soft_reset,
   input wire logic continuous,
   input wire adcsc_pkg::adcsc_regcmd_t regcmd,
   input wire logic regcmd_valid,
   input wire logic halt_pending
);
   import adcsc_pkg::*;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   desel_float_a: assert property (pins.cs_n [*4] |=> !dout_oe)
      else $error("output driven while deselected");
   sel_drive_a: assert property (!pins.cs_n [*4] |=> dout_oe)
      else $error("output not driven while selected");
   ready_load_a: assert property (conv_done && converting && !standby |=> !result_ready_n)
      else $error("ready not low after new data");
   frame_msb_a: assert property (conv_done && converting && continuous && !standby && !dout_oe
      |=> dout)
      else $error("frame does not start with a one");
   halt_done_a: assert property (halt_pending && conv_done |=> !converting)
      else $error("conversions not halted");
   stby_hold_a: assert property (standby && !converting |=> !converting)
      else $error("conversion started in standby");
   reg_kind_a: assert property (regcmd_valid |-> (regcmd.reg_rd ^ regcmd.reg_wr) && !continuous)
      else $error("bad register command");
   rst_busy_a: assert property (soft_reset |=> (!soft_reset && !regcmd_valid) [*8])
      else $error("command taken during reset");
   rst_default_a: assert property (soft_reset |-> ##[1:40] continuous)
      else $error("continuous mode not restored");
endmodule
bind adcsc_chain adcsc_chain_assertions #(.RESET_CYC(RESET_CYC)) chk_u (.clk(clk), .rst_b(rst_b),
   .pins(pins), .conv_done(conv_done), .dout(dout), .dout_oe(dout_oe),
   .result_ready_n(result_ready_n), .converting(converting), .standby(standby),
   .soft_reset(soft_reset), .continuous(continuous), .regcmd(regcmd),
   .regcmd_valid(regcmd_valid), .halt_pending(halt_pending));

/* File: sim/adcsc_chain_test.sv */
`timescale 1ns/1ps
// ====
// bench top
module adcsc_chain_test;
   import adcsc_pkg::*;
   localparam int RC = 18;
   logic clk, rst_b, chain_enable, conv_done, dout, dout_oe, result_ready_n;
   logic converting, standby, soft_reset, continuous, regcmd_valid, halt_pending, q;
   adcsc_pins_t pins;
   adcsc_result_t result;
   adcsc_regcmd_t regcmd, seen;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;
   int n_reg = 0;
   int n_rst = 0;
   int unsigned s;
   logic [151:0] f;
   logic [7:0] cb;
   logic [4:0] a, c;
   adcsc_chain #(.RESET_CYC(RC)) dut_u (.clk(clk), .rst_b(rst_b), .pins(pins),
      .chain_enable(chain_enable), .conv_done(conv_done), .result(result), .dout(dout),
      .dout_oe(dout_oe), .result_ready_n(result_ready_n), .converting(converting),
      .standby(standby), .soft_reset(soft_reset), .continuous(continuous),
      .regcmd(regcmd), .regcmd_valid(regcmd_valid), .halt_pending(halt_pending));
   adcsc_host host_u (.clk(clk), .dout(dout), .pins(pins));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic test_done();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [151:0] e, input logic [151:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // status pattern then the result fields
   function automatic logic [151:0] frame_of(input adcsc_result_t r);
      return {4'hc, r};
   endfunction
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (regcmd_valid === 1'b1) begin
         seen <= regcmd;
         n_reg <= n_reg + 1;
      end
      if (soft_reset === 1'b1) n_rst <= n_rst + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         test_done();
      end
   end
   task automatic cmd(input logic [7:0] b);
      host_u.sel(1'b0);
      host_u.op(b);
      host_u.sel(1'b1);
   endtask
   task automatic pulse();
      logic [159:0] t;
      t = {$urandom(), $urandom(), $urandom(), $urandom(), $urandom()};
      @(posedge clk);
      result <= t[147:0];
      conv_done <= 1'b1;
      @(posedge clk);
      conv_done <= 1'b0;
      f = frame_of(t[147:0]);
      repeat (2) @(posedge clk);
   endtask
   // 152 frame bits, one gap bit, then 8 tail bits
   task automatic readout(input logic [7:0] tail);
      logic [160:0] v;
      host_u.sel(1'b0);
      for (int i = 0; i < 161; i++) begin
         host_u.bitx(1'b0, cb[7 - (i % 8)], q);
         v = {v[159:0], q};
      end
      chk("frame", f, v[160:9]);
      chk("tail", tail, v[7:0]);
      chk("ready_n", 1, result_ready_n);
      chk("dout_oe", 1, dout_oe);
      host_u.sel(1'b1);
   endtask
   initial begin
      s = $urandom(32'h927d);
      rst_b = 1'b0;
      chain_enable = 1'b0;
      conv_done = 1'b0;
      result = '0;
      cb = '0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      chk("continuous", 1, continuous);
      chk("dout_oe", 0, dout_oe);
      cmd(8'h11); // stop continuous before anything else
      chk("continuous", 0, continuous);
      cmd(8'h04);
      chk("standby", 1, standby);
      cmd(8'h08);
      chk("converting", 0, converting);
      host_u.sel(1'b0);
      repeat (3) host_u.bitx(1'b1, 1'b0, q);
      host_u.sel(1'b1);
      cmd(8'h02);
      chk("standby", 0, standby);
      cmd(8'h08);
      cmd(8'h08);
      chk("converting", 1, converting);
      cmd(8'h0a);
      chk("halt_pending", 1, halt_pending);
      chk("converting", 1, converting);
      pulse();
      chk("converting", 0, converting);
      for (int k = 1; k <= 2; k++) begin
         chain_enable <= 1'($urandom()); // decode does not depend on chaining
         a = 5'($urandom());
         c = 5'($urandom());
         host_u.sel(1'b0);
         host_u.op({3'(k), a});
         host_u.op({3'h0, c});
         host_u.sel(1'b1);
         chk("regcmd", {k == 1, k == 2, a, c}, seen);
      end
      chk("reg count", 2, n_reg);
      chain_enable <= 1'b0;
      repeat (16) begin
         @(posedge clk);
         conv_done <= 1'($urandom());
      end
      @(posedge clk);
      conv_done <= 1'b0;
      @(posedge clk);
      chk("ready_n", 1, result_ready_n);
      chk("converting", 0, converting);
      cmd(8'h06);
      repeat (RC + 4) @(posedge clk); // idle while reset is busy
      chk("soft reset", 1, n_rst);
      chk("continuous", 1, continuous);
      cmd(8'h11);
      cmd(8'h08);
      cmd(8'h10); // far from any ready pulse
      pulse();
      chk("ready_n", 0, result_ready_n);
      readout(8'h00);
      chain_enable <= 1'b1;
      cb = 8'($urandom());
      pulse();
      readout(cb);
      chain_enable <= 1'b0;
      cmd(8'h11);
      pulse();
      cmd(8'h12);
      readout(f[150:143]);
      test_done();
   end
endmodule

/* File: sim/adcsc_host.sv */
`timescale 1ns/1ps
// ====
// host serial master
module adcsc_host
   import adcsc_pkg::*;
(
   input wire logic clk,
   input wire logic dout,
   output adcsc_pkg::adcsc_pins_t pins
);
   import adcsc_pkg::*;
   initial pins = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0, chain_in: 1'b0};
   // gaps of 8 tCLK cover every 4 tCLK wait
   // select moves between commands and also after a partial byte
   task automatic sel(input logic v);
      repeat (8) @(posedge clk);
      pins.cs_n <= v;
      pins.din <= ~pins.din;
      repeat (8) @(posedge clk);
   endtask
   // sclk stands still between bits; chain bit shared per clock
   task automatic bitx(input logic d, input logic c, output logic q);
      @(posedge clk);
      pins.din <= d;
      pins.chain_in <= c;
      repeat (3) @(posedge clk);
      @(negedge clk) q = dout;
      @(posedge clk);
      pins.sclk <= 1'b1;
      repeat (4) @(posedge clk);
      pins.sclk <= 1'b0;
   endtask
   task automatic op(input logic [7:0] b);
      logic q;
      for (int i = 7; i >= 0; i--) bitx(b[i], ~b[i], q);
   endtask
endmodule

/* File: src/adcsc_chain.sv */
`timescale 1ns/1ps
`include "adcsc_params.svh"
module adcsc_chain
   import adcsc_pkg::*;
#(
   parameter int RESET_CYC = `ADCSC_RESET_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire adcsc_pkg::adcsc_pins_t pins,
   input wire logic chain_enable,
   input wire logic conv_done,
   input wire adcsc_pkg::adcsc_result_t result,
   output logic dout,
   output logic dout_oe,
   output logic result_ready_n,
   output logic converting,
   output logic standby,
   output logic soft_reset,
   output logic continuous,
   output adcsc_pkg::adcsc_regcmd_t regcmd,
   output logic regcmd_valid,
   output logic halt_pending
);
   import adcsc_pkg::*;

   // busy counter is eight bits wide
   if (RESET_CYC < 1 || RESET_CYC > 255) begin : g_bad_reset_cyc
      $error("reset count out of range");
   end

   localparam int FB = `ADCSC_FRAME_BITS;

   // ==========================================================
   // pin synchronisers
   // ==========================================================
   logic [3:0] s1_reg, s2_reg;
   logic sclk_d_reg;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         // idle pin levels, so no false sclk edge follows reset
         s1_reg <= 4'h8;
         s2_reg <= 4'h8;
         sclk_d_reg <= 1'b0;
      end else begin
         s1_reg <= pins;
         s2_reg <= s1_reg;
         sclk_d_reg <= s2_reg[2];
      end
   end
   logic cs_n, sclk, din, chain_in, rise, fall;
   assign cs_n = s2_reg[3];
   assign sclk = s2_reg[2];
   assign din = s2_reg[1];
   assign chain_in = s2_reg[0];
   assign rise = sclk & ~sclk_d_reg & ~cs_n;
   assign fall = ~sclk & sclk_d_reg & ~cs_n;

   // ==========================================================
   // command byte framing
   // ==========================================================
   logic [2:0] bit_reg;
   logic [7:0] sh_reg;
   logic [7:0] byte_now;
   assign byte_now = {sh_reg[6:0], din};
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bit_reg <= 3'h0;
         sh_reg <= 8'h00;
      end else if (cs_n) begin
         bit_reg <= 3'h0;
      end else if (fall) begin
         bit_reg <= bit_reg + 3'h1;
         sh_reg <= byte_now;
      end
   end
   // opcode bits 7..1 are known at 7th fall; lsb taken as zero, not read
   logic fall7, fall8;
   assign fall7 = fall & (bit_reg == 3'h6);
   assign fall8 = fall & (bit_reg == 3'h7);
   logic [7:0] op7;
   assign op7 = {sh_reg[5:0], din, 1'b0};

   // ==========================================================
   // command state
   // ==========================================================
   adcsc_state_t state_reg;
   logic [7:0] busy_reg;
   logic [4:0] addr_reg;
   logic rd_reg;
   logic sys_ok;
   // while busy or standby only wake is honoured
   assign sys_ok = (state_reg == ADCSC_IDLE) && !standby;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= ADCSC_IDLE;
         busy_reg <= 8'h00;
         addr_reg <= 5'h00;
         rd_reg <= 1'b0;
         regcmd <= '0;
         regcmd_valid <= 1'b0;
         soft_reset <= 1'b0;
      end else begin
         regcmd_valid <= 1'b0;
         soft_reset <= 1'b0;
         case (state_reg)
            ADCSC_IDLE: begin
               if (fall7 && sys_ok && op7 == `ADCSC_OP_RESET) begin
                  soft_reset <= 1'b1;
                  busy_reg <= 8'(RESET_CYC);
                  state_reg <= ADCSC_BUSY;
               end else if (fall8 && sys_ok && !continuous &&
                            (byte_now[7:5] == `ADCSC_PFX_REGISTER_READ_CMD ||
                             byte_now[7:5] == `ADCSC_PFX_REGISTER_WRITE_CMD)) begin
                  addr_reg <= byte_now[4:0];
                  rd_reg <= (byte_now[7:5] == `ADCSC_PFX_REGISTER_READ_CMD);
                  state_reg <= ADCSC_BYTE2;
               end
            end
            ADCSC_BYTE2: begin
               if (cs_n) begin
                  state_reg <= ADCSC_IDLE;
               end else if (fall8) begin
                  if (byte_now[7:5] == `ADCSC_PFX_CNT) begin
                     regcmd <= '{rd_reg, ~rd_reg, addr_reg, byte_now[4:0]};
                     regcmd_valid <= 1'b1;
                     state_reg <= ADCSC_DATA;
                  end else begin
                     state_reg <= ADCSC_IDLE;
                  end
               end
            end
            ADCSC_DATA: begin
               // register data bytes belong to the register file
               if (cs_n) state_reg <= ADCSC_IDLE;
            end
            ADCSC_BUSY: begin
               if (busy_reg <= 8'h01) begin
                  busy_reg <= 8'h00;
                  state_reg <= ADCSC_IDLE;
               end else begin
                  busy_reg <= busy_reg - 8'h01;
               end
            end
            default: state_reg <= ADCSC_IDLE;
         endcase
      end
   end

   // ==========================================================
   // modes: standby, conversions, readout
   // ==========================================================
   // single read only outside continuous mode
   logic rd_req;
   assign rd_req = fall7 && sys_ok && op7 == `ADCSC_OP_RD && !continuous;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         standby <= 1'b0;
      end else if (fall7 && op7 == `ADCSC_OP_WAKEUP) begin
         standby <= 1'b0;
      end else if (fall7 && sys_ok && op7 == `ADCSC_OP_STANDBY) begin
         standby <= 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         converting <= 1'b0;
         halt_pending <= 1'b0;
      end else if (soft_reset) begin
         converting <= 1'b0;
         halt_pending <= 1'b0;
      end else if (fall7 && sys_ok && op7 == `ADCSC_OP_START) begin
         converting <= 1'b1;
         halt_pending <= 1'b0;
      end else if (fall7 && sys_ok && op7 == `ADCSC_OP_STOP && converting) begin
         halt_pending <= 1'b1;
      end else if (halt_pending && conv_done) begin
         converting <= 1'b0;
         halt_pending <= 1'b0;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         continuous <= 1'b1;
      end else if (soft_reset) begin
         continuous <= 1'b1;
      end else if (fall8 && sys_ok && byte_now == `ADCSC_OP_SDC) begin
         // 10h and 11h differ only in the lsb, so wait for the whole byte
         continuous <= 1'b0;
      end else if (fall8 && sys_ok && byte_now == `ADCSC_OP_RDC) begin
         continuous <= 1'b1;
      end
   end
   logic new_data;
   assign new_data = conv_done & converting & !standby;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         result_ready_n <= 1'b1;
      end else if (new_data) begin
         result_ready_n <= 1'b0;
      end else if (fall) begin
         result_ready_n <= 1'b1;
      end
   end

   // ==========================================================
   // output frame shifter
   // ==========================================================
   logic [FB-1:0] fr_reg, latch_reg;
   logic [7:0] cnt_reg;
   logic rd_mode_reg;
   // rest of the read opcode byte must not move the frame
   logic rd_skip_reg;

   // one-rise delay on the chain input makes the gap bit
   logic chain_d_reg;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         chain_d_reg <= 1'b0;
      end else if (rise) begin
         chain_d_reg <= chain_in;
      end
   end

   logic [FB-1:0] frame_now;
   assign frame_now = {`ADCSC_SYNC_PAT, result.fault_p, result.fault_n,
                       result.gpio, result.chan};
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         latch_reg <= '0;
      end else if (new_data) begin
         latch_reg <= frame_now;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fr_reg <= '0;
         cnt_reg <= 8'h00;
         rd_mode_reg <= 1'b0;
         rd_skip_reg <= 1'b0;
         dout <= 1'b0;
      end else if (new_data && continuous && (cs_n || cnt_reg == 8'h00)) begin
         fr_reg <= frame_now;
         cnt_reg <= 8'(FB);
         rd_mode_reg <= 1'b0;
         rd_skip_reg <= 1'b0;
         dout <= frame_now[FB-1];
      end else if (rd_req) begin
         fr_reg <= latch_reg;
         cnt_reg <= 8'(FB);
         rd_mode_reg <= 1'b1;
         rd_skip_reg <= 1'b1;
         dout <= latch_reg[FB-1];
      end else if (rise && rd_skip_reg) begin
         // last rise of the read opcode byte keeps the msb
         rd_skip_reg <= 1'b0;
      end else if (rise && cnt_reg != 8'h00) begin
         // chained: shift chain input behind own frame; unchained: rotate the frame
         fr_reg <= {fr_reg[FB-2:0], chain_enable ? chain_d_reg : fr_reg[FB-1]};
         dout <= fr_reg[FB-2];
         if (chain_enable || !rd_mode_reg || cnt_reg != 8'h01) begin
            cnt_reg <= (chain_enable && cnt_reg == 8'h01) ? 8'h01 : cnt_reg - 8'h01;
         end else begin
            cnt_reg <= 8'(FB); // single read repeats frame
         end
      end else if (rise && chain_enable) begin
         fr_reg <= {fr_reg[FB-2:0], chain_d_reg};
         dout <= fr_reg[FB-2];
      end else if (rise && !chain_enable && !rd_mode_reg) begin
         dout <= 1'b0; // no readback in continuous after frame
      end
   end
   // chained mode never rearms the frame, so no repeat
   assign dout_oe = ~cs_n;
endmodule

/* File: src/adcsc_params.svh */
`ifndef ADCSC_PARAMS_SVH
`define ADCSC_PARAMS_SVH
`define ADCSC_OP_WAKEUP 8'h02
`define ADCSC_OP_STANDBY 8'h04
`define ADCSC_OP_RESET 8'h06
`define ADCSC_OP_START 8'h08
`define ADCSC_OP_STOP 8'h0a
`define ADCSC_OP_RDC 8'h10
`define ADCSC_OP_SDC 8'h11
`define ADCSC_OP_RD 8'h12
`define ADCSC_PFX_REGISTER_READ_CMD 3'h1
`define ADCSC_PFX_REGISTER_WRITE_CMD 3'h2
`define ADCSC_PFX_CNT 3'h0
`define ADCSC_SYNC_PAT 4'hc
`define ADCSC_FRAME_BITS 152
`define ADCSC_RESET_CYC 18
`endif

/* File: src/adcsc_pkg.sv */
package adcsc_pkg;
   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic din;
      logic chain_in;
   } adcsc_pins_t;
   typedef struct packed {
      logic [7:0] fault_p;
      logic [7:0] fault_n;
      logic [3:0] gpio;
      logic [127:0] chan;
   } adcsc_result_t;
   typedef struct packed {
      logic reg_rd;
      logic reg_wr;
      logic [4:0] addr;
      logic [4:0] count_m1;
   } adcsc_regcmd_t;
   typedef enum logic [3:0] {
      ADCSC_IDLE = 4'b0001,
      ADCSC_BYTE2 = 4'b0010,
      ADCSC_DATA = 4'b0100,
      ADCSC_BUSY = 4'b1000
   } adcsc_state_t;
endpackage
